// *** backlight_fault_status_regs_bench.sv ***
// self-checking bench for the backlight fault status registers
`timescale 1ns/1ps
`default_nettype none
module backlight_fault_status_regs_bench;
  typedef struct packed {
    logic [7:0]  lf;
    logic        uv;
    logic [10:0] t;
    logic [7:0]  f;
  } blfs_row_s;
  localparam int         LIM = 20;
  localparam logic [7:0] ID  = 8'hB5; // arbitrary codes
  logic        hclk = 1'h0, hresetn = 1'h0, ce = 1'h1, hwrite, rdy, hresp, oe, fo, bst;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [10:0] temp = 11'h0C8;
  logic [3:0]  pwm = 4'h0, led;
  blfs_pkg::blfs_led_fault_s lf = '0;
  blfs_pkg::blfs_prot_s      pr = '0;
  int          fail_count = 0, comparisons = 0, cyc = 0;
  // open-drain pin with pull-up
  wire logic   pin = oe ? fo : 1'h1;
  blfs_row_s   rows [7] = '{'{8'h10, 1'h0, 11'h0C8, 8'h98}, '{8'h02, 1'h0, 11'h0C8, 8'h58},
    '{8'h14, 1'h0, 11'h0C8, 8'hE8}, '{8'h88, 1'h0, 11'h0C8, 8'hD8},
    '{8'h00, 1'h1, 11'h0C8, 8'h01}, '{8'h00, 1'h0, 11'h4B0, 8'h02}, '{8'h00, 1'h0, 11'h0C8, 8'h00}};
  always #5 hclk = ~hclk;
  blfs_top #(.OCP_LIMIT(LIM), .PANEL_ID(ID[7]), .MAKER_ID(ID[6:3]), .REV_ID(ID[2:0])) u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(1'h1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(rdy), .hrdata(hrdata), .hreadyout(rdy), .hresp(hresp),
    .led_fault(lf), .prot(pr), .chip_enable(ce), .temp_reading(temp), .pwm_dim(pwm),
    .fault_n_out(fo), .fault_n_oe(oe), .boost_enable(bst), .led_drive(led));
  blfs_host u_host (.hclk(hclk), .hready(rdy), .hrdata(hrdata), .htrans(htrans), .haddr(haddr),
    .hwrite(hwrite), .hwdata(hwdata));
  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : check
  task automatic w(input int n);
    repeat (n) @(posedge hclk);
  endtask : w
  task automatic rd(input string n, input logic [31:0] a, input logic [31:0] e);
    u_host.xfer(1'h0, a, 32'h0, q);
    check(n, q, e);
  endtask : rd
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    u_host.xfer(1'h1, a, d, q);
  endtask : wr
  task give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  // cut a hang short; the whole run needs about three hundred cycles
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      give_verdict;
    end
  end
  initial begin
    w(5);
    hresetn <= 1'h1;
    // fault table, each row but the last latched then cleared by a read
    foreach (rows[i]) begin
      lf   <= rows[i].lf;
      pr   <= {1'h0, rows[i].uv};
      temp <= rows[i].t;
      w(6);
      check("pin", pin, rows[i].f == 8'h0);
      rd("flags", 32'h08, {24'h0, rows[i].f});
      lf   <= '0;
      pr   <= '0;
      temp <= 11'h0C8;
      w(6);
      u_host.xfer(1'h0, 32'h08, 32'h0, q);
      w(2);
      check("released", pin, 1'h1);
    end
    wr(32'h0C, 32'hFF);
    rd("id", 32'h0C, {24'h0, ID});
    rd("force rst", 32'h10, 32'h0);
    wr(32'h40, 32'hFF);
    rd("unmapped", 32'h40, 32'h0);
    wr(32'h10, 32'h5A);
    rd("force", 32'h10, 32'h0A);
    pwm <= 4'h5;
    w(4);
    check("forced", led, 4'hF);
    wr(32'h10, 32'h0);
    w(4);
    check("pwm", led, 4'h5);
    // upper byte first, it latches the lower bits
    temp <= 11'h1A5;
    w(6);
    rd("temp hi", 32'h14, 32'h34);
    temp <= 11'h1A2;
    w(6);
    rd("temp lo", 32'h18, 32'hA0);
    // thermal hold keeps outputs off until 130
    temp <= 11'h4B0;
    w(6);
    check("hot", {bst, led}, 5'h0);
    temp <= 11'h460;
    w(6);
    check("hold", {bst, led}, 5'h0);
    temp <= 11'h410;
    w(6);
    check("cooled", {bst, led}, 5'h15);
    temp <= 11'h0C8;
    u_host.xfer(1'h0, 32'h08, 32'h0, q);
    // a dip shorter than the limit must not trip
    pr <= 2'h2;
    w(LIM - 5);
    pr <= 2'h0;
    w(6);
    rd("short dip", 32'h08, 32'h0);
    pr <= 2'h2;
    w(LIM + 8);
    check("boost off", bst, 1'h0);
    pr <= 2'h0;
    w(3);
    rd("ocp", 32'h08, 32'h04);
    w(5);
    check("restart", bst, 1'h1);
    // enable low clears a latched flag
    lf <= 8'h10;
    w(6);
    lf <= '0;
    ce <= 1'h0;
    w(6);
    check("en low", {bst, pin}, 2'h1);
    ce <= 1'h1;
    w(6);
    rd("en clr", 32'h08, 32'h0);
    // reset in mid-run
    wr(32'h10, 32'hF);
    hresetn <= 1'h0;
    w(3);
    check("in reset", {hrdata[7:0], bst, led, oe}, 14'h0);
    hresetn <= 1'h1;
    w(2);
    rd("force rst", 32'h10, 32'h0);
    give_verdict;
  end
endmodule : backlight_fault_status_regs_bench
bind blfs_top blfs_checker #(.OCP_LIMIT(OCP_LIMIT), .PANEL_ID(PANEL_ID), .MAKER_ID(MAKER_ID),
  .REV_ID(REV_ID)) u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .led_fault(led_fault), .prot(prot), .chip_enable(chip_enable),
  .temp_reading(temp_reading), .pwm_dim(pwm_dim), .fault_n_out(fault_n_out),
  .fault_n_oe(fault_n_oe), .boost_enable(boost_enable), .led_drive(led_drive));
`default_nettype wire

// *** blfs_checker.sv ***
// checker: bus answers and fault behaviour seen at the top ports
`timescale 1ns/1ps
`default_nettype none
module blfs_checker #(
  parameter int         OCP_LIMIT = 20,
  parameter logic       PANEL_ID  = 1'h0,
  parameter logic [3:0] MAKER_ID  = 4'h0,
  parameter logic [2:0] REV_ID    = 3'h0
) (
  input wire logic                      hclk,
  input wire logic                      hresetn,
  input wire logic                      hsel,
  input wire logic [31:0]               haddr,
  input wire logic [1:0]                htrans,
  input wire logic                      hwrite,
  input wire logic                      hready,
  input wire logic [31:0]               hrdata,
  input wire logic                      hreadyout,
  input wire logic                      hresp,
  input wire blfs_pkg::blfs_led_fault_s led_fault,
  input wire blfs_pkg::blfs_prot_s      prot,
  input wire logic                      chip_enable,
  input wire logic [10:0]               temp_reading,
  input wire logic [3:0]                pwm_dim,
  input wire logic                      fault_n_out,
  input wire logic                      fault_n_oe,
  input wire logic                      boost_enable,
  input wire logic [3:0]                led_drive
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // read taken, and no hold condition on the outputs
  wire logic rd   = hsel && hready && htrans[1] && !hwrite;
  wire logic cool = temp_reading < 11'h410 && !prot.undervolt;
  int low_r;
  int low_nxt;
  // run length of boost low at the pin
  always_comb low_nxt = prot.boost_low ? low_r + 1 : 0;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) low_r <= 0;
    else low_r <= low_nxt;
  end
  a_bus_okay: assert property (hreadyout && !hresp) else $error("bus not ready or not okay");
  a_fault_pin: assert property (
    (|led_fault && chip_enable && !rd)[*5] |-> fault_n_oe && !fault_n_out)
    else $error("fault pin not pulled");
  a_read_clear: assert property (
    (led_fault == '0 && !prot.boost_low && cool)[*4] ##0 (rd && haddr == 32'h08)
    |-> ##3 !fault_n_oe) else $error("read did not release pin");
  // boost cut only after long dip
  a_ocp_time: assert property (
    $fell(boost_enable) && chip_enable && cool |-> low_r > OCP_LIMIT)
    else $error("boost cut too early");
  a_hot_off: assert property (
    (temp_reading >= 11'h4B0)[*6] |-> led_drive == 4'h0 && !boost_enable)
    else $error("outputs on while hot");
  a_uv_off: assert property (
    prot.undervolt[*6] |-> led_drive == 4'h0 && !boost_enable)
    else $error("outputs on in undervoltage");
  a_pwm_pass: assert property (
    cool[*6] |=> (led_drive & $past(pwm_dim)) == $past(pwm_dim))
    else $error("pwm lost on output");
  a_id_value: assert property (
    rd && haddr == 32'h0C |=> hrdata == {24'h0, PANEL_ID, MAKER_ID, REV_ID})
    else $error("id value wrong");
  a_temp_high: assert property (
    $stable(temp_reading)[*4] ##0 (rd && haddr == 32'h14)
    |=> hrdata == {24'h0, $past(temp_reading[10:3])}) else $error("temp upper byte wrong");
  c_ocp: cover property ($fell(boost_enable) && prot.boost_low);
  c_read_fault: cover property (rd && haddr == 32'h08 && fault_n_oe);
  c_hot: cover property (temp_reading >= 11'h4B0 && led_drive == 4'h0);
endmodule : blfs_checker
`default_nettype wire

// *** blfs_host.sv ***
// ahb-lite master model standing in for host software
`timescale 1ns/1ps
`default_nettype none
module blfs_host (
  input  wire logic        hclk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic      [1:0]  htrans,
  output logic      [31:0] haddr,
  output logic             hwrite,
  output logic      [31:0] hwdata
);
  // idle bus from time zero
  initial begin
    htrans = 2'h0;
    haddr  = 32'h0;
    hwrite = 1'h0;
    hwdata = 32'h0;
  end
  // one word transfer; released data shows its inverse so stale values never match
  task xfer(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'h1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'h1);
    q = hrdata;
    hwdata <= ~d;
  endtask : xfer
endmodule : blfs_host
`default_nettype wire

// *** blfs_ocp_timer.sv ***
// timer: boost output held low longer than the limit
`timescale 1ns/1ps
`default_nettype none
module blfs_ocp_timer #(
  parameter int LIMIT = 5_000_000
) (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic low,
  output logic      expired
);
  logic [31:0] cnt_r;
  logic [31:0] cnt_nxt;
  // count while low, restart on any recovery
  always_comb begin
    cnt_nxt = cnt_r;
    if (!low) begin
      cnt_nxt = 32'h0;
    end else if (cnt_r <= LIMIT[31:0]) begin
      cnt_nxt = cnt_r + 32'h1;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r <= 32'h0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
  // more than the limit, not equal to it
  assign expired = (cnt_r > LIMIT[31:0]);
endmodule : blfs_ocp_timer
`default_nettype wire

// *** blfs_pkg.sv ***
// package: register map, fields, timing and carrier types for backlight fault block
// Function
// [RQ1] open led string sets bit 7 and pulls fault pin low
// [RQ2] shorted led string sets bit 6 and pulls fault pin low
// [RQ3] bit 5 set when two or more channels report a fault
// [RQ4] bit 4 set when exactly one channel reports a fault
// [RQ5] bit 3 is the or of all led fault conditions
// [RQ6] fault flags clear on read of offset 02h or enable low
// [RQ7] fault pin held low while any fault flag is set
// [RQ8] boost low over 50 ms sets bit 2 and disables boost
// [RQ9] boost restarts automatically once over-current flag is cleared
// [RQ10] at 150C set bit 1, outputs off until 130C reached
// [RQ11] under-voltage sets bit 0, outputs off until input above threshold
// [RQ12] force bit 0 gives pwm dimming, 1 gives full duty
// [RQ13] id register read-only: panel bit 7, maker 6:3, revision 2:0
// [RQ14] upper temperature read latches lower bits; upper read before lower
package blfs_pkg;
  // register indices as printed; byte address is four times the index
  localparam logic [7:0] IDX_FAULT = 8'h02;
  localparam logic [7:0] IDX_ID    = 8'h03;
  localparam logic [7:0] IDX_FORCE = 8'h04;
  localparam logic [7:0] IDX_TEMPH = 8'h05;
  localparam logic [7:0] IDX_TEMPL = 8'h06;
  // fault register bit positions
  localparam int B_OPEN  = 7;
  localparam int B_SHORT = 6;
  localparam int B_MULTI = 5;
  localparam int B_ONE   = 4;
  localparam int B_ANY   = 3;
  localparam int B_OCP   = 2;
  localparam int B_TSD   = 1;
  localparam int B_INPUT_UNDERVOLTAGE_FLAG  = 0;
  // reset values
  localparam logic [7:0] FAULT_RST = 8'h00;
  localparam logic [7:0] FORCE_RST = 8'h00;
  localparam logic [7:0] TEMPH_RST = 8'h00;
  localparam logic [2:0] TEMPL_RST = 3'h0;
  // temperature thresholds in degrees, integer part of the 11-bit reading >> 3
  localparam logic [7:0] TSD_SET_C   = 8'h96; // 150
  localparam logic [7:0] TSD_CLEAR_C = 8'h82; // 130
  // timing
  localparam int CLK_HZ      = 100_000_000;
  localparam int OCP_TIME_MS = 50;
  localparam int OCP_CYCLES  = (CLK_HZ / 1000) * OCP_TIME_MS;
  localparam int NUM_CH      = 4;
  // led fault carrier from the analog detectors
  typedef struct packed {
    logic [NUM_CH-1:0] open_ch;
    logic [NUM_CH-1:0] short_ch;
  } blfs_led_fault_s;
  // protection inputs carrier
  typedef struct packed {
    logic boost_low;
    logic undervolt;
  } blfs_prot_s;
endpackage : blfs_pkg

// *** blfs_sync.sv ***
// two-flop synchroniser for a vector of pin levels
`timescale 1ns/1ps
`default_nettype none
module blfs_sync #(
  parameter int W = 1
) (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;
  logic [W-1:0] q_r;
  // first stage feeds only the second stage
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_r <= '0;
      q_r    <= '0;
    end else begin
      meta_r <= d;
      q_r    <= meta_r;
    end
  end
  assign q = q_r;
endmodule : blfs_sync
`default_nettype wire

// *** blfs_top.sv ***
// backlight fault status registers with ahb-lite slave
//
// Chosen here: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module blfs_top #(
  parameter int         OCP_LIMIT = blfs_pkg::OCP_CYCLES,
  parameter logic       PANEL_ID  = 1'h1, // arbitrary
  parameter logic [3:0] MAKER_ID  = 4'hA, // arbitrary
  parameter logic [2:0] REV_ID    = 3'h1  // arbitrary
) (
  input  wire logic                     hclk,
  input  wire logic                     hresetn,
  input  wire logic                     hsel,
  input  wire logic [31:0]              haddr,
  input  wire logic [1:0]               htrans,
  input  wire logic                     hwrite,
  input  wire logic [2:0]               hsize,
  input  wire logic [31:0]              hwdata,
  input  wire logic                     hready,
  output logic      [31:0]              hrdata,
  output logic                          hreadyout,
  output logic                          hresp,
  input  wire blfs_pkg::blfs_led_fault_s led_fault,
  input  wire blfs_pkg::blfs_prot_s      prot,
  input  wire logic                     chip_enable,
  input  wire logic [10:0]              temp_reading,
  input  wire logic [3:0]               pwm_dim,
  output logic                          fault_n_out,
  output logic                          fault_n_oe,
  output logic                          boost_enable,
  output logic      [3:0]               led_drive
);
  localparam int NCH = blfs_pkg::NUM_CH;

  // pins from the analog side are asynchronous
  logic [2*NCH+3:0] raw_in;
  logic [2*NCH+3:0] syn_in;
  assign raw_in = {led_fault.open_ch, led_fault.short_ch, prot.boost_low,
                   prot.undervolt, chip_enable, 1'b0};
  blfs_sync #(.W(2*NCH+4)) u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .d       (raw_in),
    .q       (syn_in)
  );
  logic [NCH-1:0] open_s;
  logic [NCH-1:0] short_s;
  logic           boost_low_s;
  logic           uv_s;
  logic           en_s;
  assign open_s      = syn_in[2*NCH+3:NCH+4];
  assign short_s     = syn_in[NCH+3:4];
  assign boost_low_s = syn_in[3];
  assign uv_s        = syn_in[2];
  assign en_s        = syn_in[1];

  // temperature sampled via two flops per bit, then the agreement filter below
  logic [10:0] temp_s;
  blfs_sync #(.W(11)) u_tsync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .d       (temp_reading),
    .q       (temp_s)
  );

  // bits of one word can land in different cycles; take it only once two samples agree
  logic [10:0] temp_prev_r;
  logic [10:0] temp_ok_r;
  logic [10:0] temp_ok_nxt;
  always_comb begin
    temp_ok_nxt = (temp_s == temp_prev_r) ? temp_s : temp_ok_r;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      temp_prev_r <= 11'h000;
      temp_ok_r   <= 11'h000;
    end else begin
      temp_prev_r <= temp_s;
      temp_ok_r   <= temp_ok_nxt;
    end
  end

  logic ocp_expired;
  blfs_ocp_timer #(.LIMIT(OCP_LIMIT)) u_ocp (
    .hclk    (hclk),
    .hresetn (hresetn),
    .low     (boost_low_s & boost_enable),
    .expired (ocp_expired)
  );

  // count of channels with any fault
  function automatic logic [2:0] blfs_count(input logic [NCH-1:0] v);
    logic [2:0] c;
    c = 3'h0;
    for (int i = 0; i < NCH; i++) begin
      c = c + {2'h0, v[i]};
    end
    return c;
  endfunction : blfs_count

  // ahb address phase capture
  logic       dp_act_r;
  logic       dp_act_nxt;
  logic       dp_wr_r;
  logic       dp_wr_nxt;
  logic [7:0] dp_idx_r;
  logic [7:0] dp_idx_nxt;
  logic       dp_ok_r;
  logic       dp_ok_nxt;
  logic       ap_valid;
  assign ap_valid = hsel & hready & htrans[1];
  always_comb begin
    dp_act_nxt = ap_valid;
    dp_wr_nxt  = ap_valid & hwrite;
    dp_idx_nxt = haddr[9:2];
    dp_ok_nxt  = (haddr[31:10] == 22'h0) && (haddr[1:0] == 2'h0);
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_act_r <= 1'b0;
      dp_wr_r  <= 1'b0;
      dp_idx_r <= 8'h00;
      dp_ok_r  <= 1'b0;
    end else begin
      dp_act_r <= dp_act_nxt;
      dp_wr_r  <= dp_wr_nxt;
      dp_idx_r <= dp_idx_nxt;
      dp_ok_r  <= dp_ok_nxt;
    end
  end

  logic rd_fault;
  logic rd_temph;
  logic wr_force;
  assign rd_fault = dp_act_r & ~dp_wr_r & dp_ok_r & (dp_idx_r == blfs_pkg::IDX_FAULT);
  // latched on the address phase so both bytes come from the sample that is returned
  assign rd_temph = ap_valid & ~hwrite & dp_ok_nxt & (dp_idx_nxt == blfs_pkg::IDX_TEMPH);
  assign wr_force = dp_act_r & dp_wr_r & dp_ok_r & (dp_idx_r == blfs_pkg::IDX_FORCE);

  // fault, protection and register state
  logic [7:0] fault_r;
  logic [7:0] fault_nxt;
  logic [7:0] force_r;
  logic [7:0] force_nxt;
  logic [7:0] temph_r;
  logic [7:0] temph_nxt;
  logic [2:0] templ_r;
  logic [2:0] templ_nxt;
  logic       hot_r;
  logic       hot_nxt;
  logic       uv_hold_r;
  logic       uv_hold_nxt;
  logic [NCH-1:0] ch_fault;
  logic [7:0] fault_set;
  logic       clr;
  always_comb begin
    ch_fault  = open_s | short_s;
    fault_set = 8'h00;
    // [RQ1] open string flag
    fault_set[blfs_pkg::B_OPEN]  = |open_s;
    // [RQ2] short string flag
    fault_set[blfs_pkg::B_SHORT] = |short_s;
    // [RQ3] two or more
    fault_set[blfs_pkg::B_MULTI] = (blfs_count(ch_fault) >= 3'h2);
    // [RQ4] exactly one channel
    fault_set[blfs_pkg::B_ONE]   = (blfs_count(ch_fault) == 3'h1);
    // [RQ5] or of led faults
    fault_set[blfs_pkg::B_ANY]   = |ch_fault;
    // [RQ8] over-current after timeout
    fault_set[blfs_pkg::B_OCP]   = ocp_expired;
    // [RQ10] thermal trip point
    fault_set[blfs_pkg::B_TSD]   = (temp_ok_nxt[10:3] >= blfs_pkg::TSD_SET_C);
    // [RQ11] input under-voltage
    fault_set[blfs_pkg::B_INPUT_UNDERVOLTAGE_FLAG]  = uv_s;
    // [RQ6] read or enable low clears; a same-cycle event wins
    clr       = rd_fault | ~en_s;
    fault_nxt = (clr ? 8'h00 : fault_r) | fault_set;
    // [RQ10] hold off until cooled to 130
    hot_nxt = hot_r;
    if (fault_set[blfs_pkg::B_TSD]) begin
      hot_nxt = 1'b1;
    end else if (temp_ok_nxt[10:3] <= blfs_pkg::TSD_CLEAR_C) begin
      hot_nxt = 1'b0;
    end
    // [RQ11] hold off until input recovers
    uv_hold_nxt = uv_s;
    force_nxt = wr_force ? {4'h0, hwdata[3:0]} : force_r;
    // [RQ14] upper read latches lower bits
    temph_nxt = temp_ok_nxt[10:3];
    templ_nxt = rd_temph ? temp_ok_nxt[2:0] : templ_r;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fault_r   <= blfs_pkg::FAULT_RST;
      force_r   <= blfs_pkg::FORCE_RST;
      temph_r   <= blfs_pkg::TEMPH_RST;
      templ_r   <= blfs_pkg::TEMPL_RST;
      hot_r     <= 1'b0;
      uv_hold_r <= 1'b0;
    end else begin
      fault_r   <= fault_nxt;
      force_r   <= force_nxt;
      temph_r   <= temph_nxt;
      templ_r   <= templ_nxt;
      hot_r     <= hot_nxt;
      uv_hold_r <= uv_hold_nxt;
    end
  end

  // read mux on the address phase so data stands through the data phase;
  // unmapped words read zero with okay
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    if (dp_ok_nxt) begin
      case (dp_idx_nxt)
        blfs_pkg::IDX_FAULT: rd_byte = fault_nxt;
        // [RQ13] fixed identity, writes ignored
        blfs_pkg::IDX_ID:    rd_byte = {PANEL_ID, MAKER_ID, REV_ID};
        blfs_pkg::IDX_FORCE: rd_byte = force_nxt;
        blfs_pkg::IDX_TEMPH: rd_byte = temph_nxt;
        blfs_pkg::IDX_TEMPL: rd_byte = {templ_r, 5'h00};
        default:             rd_byte = 8'h00;
      endcase
    end
  end

  // outputs registered; zero wait states so hreadyout stays high
  logic [31:0] hrdata_nxt;
  logic        fault_oe_nxt;
  logic        boost_nxt;
  logic [3:0]  led_nxt;
  logic        off;
  always_comb begin
    hrdata_nxt = (ap_valid & ~hwrite) ? {24'h0, rd_byte} : hrdata;
    // [RQ7] open drain pulled low while any flag set
    fault_oe_nxt = |fault_nxt;
    off = hot_nxt | uv_hold_nxt;
    // [RQ8] boost off while flagged; [RQ9] restart once cleared
    boost_nxt = ~off & ~fault_nxt[blfs_pkg::B_OCP] & en_s;
    // [RQ12] force bit selects full duty
    led_nxt = off ? 4'h0 : (force_nxt[3:0] | pwm_dim);
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata       <= 32'h0;
      fault_n_oe   <= 1'b0;
      boost_enable <= 1'b0;
      led_drive    <= 4'h0;
    end else begin
      hrdata       <= hrdata_nxt;
      fault_n_oe   <= fault_oe_nxt;
      boost_enable <= boost_nxt;
      led_drive    <= led_nxt;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
      fault_n_out <= 1'b0;
    end else begin
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
      fault_n_out <= 1'b0;
    end
  end
endmodule : blfs_top
`default_nettype wire
